// *** uat_pkg.sv ***
package uat_pkg;
    // Register word indices on the Avalon-MM slave
    localparam logic [2:0] REG_MODE = 3'h0;
    localparam logic [2:0] REG_STA = 3'h1;
    localparam logic [2:0] REG_TX = 3'h2;
    localparam logic [2:0] REG_RX = 3'h3;
    localparam logic [2:0] REG_BRG = 3'h4;
    localparam logic [2:0] REG_IRQ = 3'h5;
    // mode_ctrl_reg fields
    localparam int MODE_EN_BIT = 15;
    localparam int MODE_ALT_BIT = 10;
    localparam int MODE_FMT_LSB = 1;
    localparam int MODE_STOP_BIT = 0;
    // status_ctrl_reg fields
    localparam int STA_TXISEL_BIT = 15;
    localparam int STA_BRK_BIT = 11;
    localparam int STA_TXEN_BIT = 10;
    localparam int STA_RXISEL_LSB = 6;
    // irq flag register fields
    localparam int IRQ_TX_BIT = 0;
    localparam int IRQ_RX_BIT = 1;
    // Reset values
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [15:0] BRG_RST = 16'h0000;
    // frame_format_sel codes
    localparam logic [1:0] FMT_8N = 2'h0;
    localparam logic [1:0] FMT_8E = 2'h1;
    localparam logic [1:0] FMT_8O = 2'h2;
    localparam logic [1:0] FMT_9N = 2'h3;
    localparam logic [1:0] RXI_THREE_SEL = 2'h2;
    localparam logic [1:0] RXI_FULL_SEL = 2'h3;
    localparam int RXI_THREE_CNT = 3;
    // Bit timing: 16 baud ticks per bit, sample on tick 7
    localparam logic [3:0] SUB_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_PT = 4'h7;
    localparam logic [3:0] FRAME_BASE = 4'ha;

    typedef enum logic [1:0] {RX_IDLE, RX_RUN, RX_BRKWAIT} uat_rxst_t;

    typedef struct packed {
        logic parity_err;
        logic framing_err;
        logic [8:0] data;
    } uat_rxword_t;
endpackage : uat_pkg

// *** uat_serial.sv ***
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/100ps
// Function
// - alt_pin_select one uses alternate pins, zero uses primary pins.
// - Format field picks 8 bits with none/even/odd parity or 9 bits; stop select.
// - After reset the format is 8 data bits, no parity, one stop bit.
// - With tx enabled and no break, a written word moves at once to the shift register if the shifter is idle.
// - Word written while tx disabled starts immediately when tx is enabled.
// - Transmit buffer holds four 9-bit words; tx_buf_full reports full.
// - A write to a full transmit buffer is dropped, contents unchanged.
// - Device reset empties both buffers.
// - Tx flag set per word moved, or only when move leaves buffer empty.
// - Break control forces the transmit output low over everything.
// - Sending a break raises no transmit flag.
// - Reading rx data advances the queue; parity/framing bits follow the head.
// - Receive buffer holds four words; rx_data_avail shows non-empty.
// - Reading an empty receive buffer returns old value, no shift.
// - Rx flag on push: every word, three words, or four words held.
// - Stop with full buffer sets overrun; reception halts until cleared.
// - Framing error if any stop bit low, stored per word.
// - Parity error stored per word when a parity mode is selected.
// - Rx idle is zero from start detect until stop completes.
// - Long break gives a zero word with framing error, then waits for high.
// - Bit rate is clock over sixteen times divider plus one.
// - Transmit output rests high when no frame is sent.
// - Disabling empties buffers, resets baud counter, clears overrun, tx enable and break; irq flags kept.
module uat_serial
    import uat_pkg::*;
#(
    parameter int TXQ_DEPTH = 4,
    parameter int RXQ_DEPTH = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rx_pin,
    input wire logic alt_rx_pin,
    output logic tx_pin,
    output logic alt_tx_pin,
    output logic tx_irq_flag,
    output logic rx_irq_flag
);
    localparam int TCW = $clog2(TXQ_DEPTH + 1);
    localparam int RCW = $clog2(RXQ_DEPTH + 1);

    typedef struct packed {
        logic [2:0] rxS;
        logic rxF;
        logic rxPrev;
        logic [15:0] mode;
        logic [15:0] brg;
        logic txIsel;
        logic brk;
        logic txEn;
        logic [1:0] rxIsel;
        logic rx_overrun_err;
        logic txIrq;
        logic rxIrq;
        logic [15:0] brgCnt;
        logic [TXQ_DEPTH-1:0][8:0] txq;
        logic [TCW-1:0] txCnt;
        logic busy;
        logic [12:0] txSh;
        logic [3:0] txLen;
        logic [3:0] txBit;
        logic [3:0] txSub;
        uat_rxst_t rxSt;
        logic [3:0] rxSub;
        logic [3:0] rxBit;
        logic [12:0] rsr;
        uat_rxword_t [RXQ_DEPTH-1:0] rxq;
        logic [RCW-1:0] rxCnt;
        uat_rxword_t lastRd;
        logic waitr;
        logic [31:0] rdata;
        logic popArm;
        logic txPin;
        logic altTxPin;
    } uat_state_t;

    localparam uat_state_t ST_RST = '{rxS: 3'h7, rxF: 1'b1, rxPrev: 1'b1, mode: MODE_RST,
        brg: BRG_RST, rxSt: RX_IDLE, waitr: 1'b1, txPin: 1'b1, altTxPin: 1'b1, default: '0};

    uat_state_t s_r, s_nxt;
    logic en, alt, nine, par, odd, stop2, tick, txLoad, txIrqEv, commit, rxFall;
    logic rxFinish, rxPush, rxPop, txOut;
    logic [1:0] fmt;
    logic [3:0] len;
    logic [12:0] fr, rv;
    logic [15:0] rdMux;
    logic [8:0] rxData;
    logic ferrNow, perrNow;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (wd[15:0] & m);
    endfunction : merge16

    always_comb begin
        s_nxt = s_r;
        en = s_r.mode[MODE_EN_BIT];
        alt = s_r.mode[MODE_ALT_BIT];
        fmt = s_r.mode[MODE_FMT_LSB+:2];
        stop2 = s_r.mode[MODE_STOP_BIT];
        nine = (fmt == FMT_9N);
        par = (fmt == FMT_8E) || (fmt == FMT_8O);
        odd = (fmt == FMT_8O);
        len = FRAME_BASE + {3'h0, par} + {3'h0, nine} + {3'h0, stop2};
        tick = 1'b0;
        txLoad = 1'b0;
        txIrqEv = 1'b0;
        commit = 1'b0;
        rxFinish = 1'b0;
        rxPush = 1'b0;
        rxPop = 1'b0;
        rv = s_r.rsr;
        rxData = '0;
        ferrNow = 1'b0;
        perrNow = 1'b0;
        rdMux = '0;

        // Pin select, then three-stage sync; a level counts once stages two and three agree
        s_nxt.rxS = {s_r.rxS[1:0], alt ? alt_rx_pin : rx_pin};
        if (s_r.rxS[1] == s_r.rxS[2]) begin
            s_nxt.rxF = s_r.rxS[2];
        end
        s_nxt.rxPrev = s_r.rxF;
        rxFall = s_r.rxPrev && !s_r.rxF;

        // Sixteen ticks per bit
        if (s_r.brgCnt >= s_r.brg) begin
            s_nxt.brgCnt = '0;
            tick = en;
        end else begin
            s_nxt.brgCnt = s_r.brgCnt + 16'h1;
        end

        // Frame image, start bit first, stop bits preset high
        fr = '1;
        fr[0] = 1'b0;
        if (nine) begin
            fr[9:1] = s_r.txq[0];
        end else begin
            fr[8:1] = s_r.txq[0][7:0];
            if (par) begin
                fr[9] = ^s_r.txq[0][7:0] ^ odd;
            end
        end

        // Load at once; sub-count restarts so the start bit goes out right away
        if (en && s_r.txEn && !s_r.brk && !s_r.busy && s_r.txCnt != '0) begin
            txLoad = 1'b1;
            s_nxt.busy = 1'b1;
            s_nxt.txSh = fr;
            s_nxt.txLen = len;
            s_nxt.txBit = '0;
            s_nxt.txSub = '0;
            for (int i = 0; i < TXQ_DEPTH - 1; i++) begin
                s_nxt.txq[i] = s_r.txq[i+1];
            end
            s_nxt.txCnt = s_r.txCnt - TCW'(1);
            txIrqEv = !s_r.txIsel || (s_r.txCnt == TCW'(1));
        end else if (s_r.busy && tick) begin
            s_nxt.txSub = s_r.txSub + 4'h1;
            if (s_r.txSub == SUB_LAST) begin
                s_nxt.txSh = {1'b1, s_r.txSh[12:1]};
                s_nxt.txBit = s_r.txBit + 4'h1;
                if (s_r.txBit == s_r.txLen - 4'h1) begin
                    s_nxt.busy = 1'b0;
                end
            end
        end

        // Register read image
        case (avs_address)
            REG_MODE: rdMux = s_r.mode;
            REG_STA: rdMux = {s_r.txIsel, 3'h0, s_r.brk, s_r.txEn,
                              s_r.txCnt == TCW'(TXQ_DEPTH), !s_r.busy,
                              s_r.rxIsel, 1'b0, s_r.rxSt != RX_RUN,
                              s_r.rxCnt != '0 && s_r.rxq[0].parity_err,
                              s_r.rxCnt != '0 && s_r.rxq[0].framing_err,
                              s_r.rx_overrun_err, s_r.rxCnt != '0};
            REG_RX: rdMux = {7'h0, s_r.rxCnt != '0 ? s_r.rxq[0].data : s_r.lastRd.data};
            REG_BRG: rdMux = s_r.brg;
            REG_IRQ: rdMux = {14'h0, s_r.rxIrq, s_r.txIrq};
            default: rdMux = '0;
        endcase

        // Avalon slave: one wait cycle, then the access takes effect
        if ((avs_read || avs_write) && s_r.waitr) begin
            s_nxt.waitr = 1'b0;
            s_nxt.rdata = {16'h0, rdMux};
            s_nxt.popArm = avs_read && avs_address == REG_RX && s_r.rxCnt != '0;
        end else if (!s_r.waitr) begin
            s_nxt.waitr = 1'b1;
            commit = avs_read || avs_write;
            s_nxt.popArm = 1'b0;
        end
        if (commit && avs_write) begin
            case (avs_address)
                REG_MODE: s_nxt.mode = merge16(s_r.mode, avs_writedata, avs_byteenable);
                REG_BRG: s_nxt.brg = merge16(s_r.brg, avs_writedata, avs_byteenable);
                REG_STA: begin
                    if (avs_byteenable[1]) begin
                        s_nxt.txIsel = avs_writedata[STA_TXISEL_BIT];
                        s_nxt.brk = avs_writedata[STA_BRK_BIT];
                        s_nxt.txEn = avs_writedata[STA_TXEN_BIT];
                    end
                    if (avs_byteenable[0]) begin
                        s_nxt.rxIsel = avs_writedata[STA_RXISEL_LSB+:2];
                        s_nxt.rx_overrun_err = s_r.rx_overrun_err && avs_writedata[1];
                    end
                end
                REG_TX: begin
                    if (avs_byteenable[0] && en && s_r.txCnt != TCW'(TXQ_DEPTH)) begin
                        s_nxt.txq[s_nxt.txCnt] = avs_writedata[8:0];
                        s_nxt.txCnt = s_nxt.txCnt + TCW'(1);
                    end
                end
                REG_IRQ: begin
                    if (avs_byteenable[0]) begin
                        s_nxt.txIrq = s_r.txIrq && !avs_writedata[IRQ_TX_BIT];
                        s_nxt.rxIrq = s_r.rxIrq && !avs_writedata[IRQ_RX_BIT];
                    end
                end
                default: ;
            endcase
        end
        if (commit && avs_read && s_r.popArm) begin
            rxPop = 1'b1;
            s_nxt.lastRd = s_r.rxq[0];
            for (int i = 0; i < RXQ_DEPTH - 1; i++) begin
                s_nxt.rxq[i] = s_r.rxq[i+1];
            end
            s_nxt.rxCnt = s_r.rxCnt - RCW'(1);
        end
        // Hardware set wins over a same-cycle software clear
        if (txIrqEv) begin
            s_nxt.txIrq = 1'b1;
        end

        // Receiver
        rv[s_r.rxBit] = s_r.rxF;
        rxData = nine ? rv[9:1] : {1'b0, rv[8:1]};
        ferrNow = !rv[len-4'h1] || (stop2 && !rv[len-4'h2]);
        perrNow = par && (rv[9] != (^rv[8:1] ^ odd));
        case (s_r.rxSt)
            RX_IDLE: begin
                if (en && !s_r.rx_overrun_err && rxFall) begin
                    s_nxt.rxSt = RX_RUN;
                    s_nxt.rxSub = '0;
                    s_nxt.rxBit = '0;
                end
            end
            RX_RUN: begin
                if (tick) begin
                    s_nxt.rxSub = s_r.rxSub + 4'h1;
                    if (s_r.rxSub == SAMPLE_PT) begin
                        s_nxt.rsr = rv;
                        s_nxt.rxBit = s_r.rxBit + 4'h1;
                        if (s_r.rxBit == '0 && s_r.rxF) begin
                            s_nxt.rxSt = RX_IDLE;
                        end else if (s_r.rxBit == len - 4'h1) begin
                            rxFinish = 1'b1;
                            s_nxt.rxSt = (ferrNow && rxData == '0) ? RX_BRKWAIT : RX_IDLE;
                        end
                    end
                end
            end
            RX_BRKWAIT: begin
                if (s_r.rxF) begin
                    s_nxt.rxSt = RX_IDLE;
                end
            end
            default: s_nxt.rxSt = RX_IDLE;
        endcase
        if (rxFinish) begin
            if (s_nxt.rxCnt == RCW'(RXQ_DEPTH)) begin
                s_nxt.rx_overrun_err = 1'b1;
            end else begin
                rxPush = 1'b1;
                s_nxt.rxq[s_nxt.rxCnt] = '{parity_err: perrNow, framing_err: ferrNow, data: rxData};
                s_nxt.rxCnt = s_nxt.rxCnt + RCW'(1);
                case (s_r.rxIsel)
                    // Keeps a same-cycle software clear unless this push sets the flag
                    RXI_THREE_SEL: s_nxt.rxIrq = s_nxt.rxIrq || s_nxt.rxCnt == RCW'(RXI_THREE_CNT);
                    RXI_FULL_SEL: s_nxt.rxIrq = s_nxt.rxIrq || s_nxt.rxCnt == RCW'(RXQ_DEPTH);
                    default: s_nxt.rxIrq = 1'b1;
                endcase
            end
        end

        // Module disabled: drop everything in flight, clear tx enable and break, keep other configuration
        if (!s_nxt.mode[MODE_EN_BIT]) begin
            s_nxt.txCnt = '0;
            s_nxt.rxCnt = '0;
            s_nxt.busy = 1'b0;
            s_nxt.brgCnt = '0;
            s_nxt.rx_overrun_err = 1'b0;
            s_nxt.txEn = 1'b0;
            s_nxt.brk = 1'b0;
            s_nxt.rxSt = RX_IDLE;
        end

        txOut = s_nxt.brk ? 1'b0 : (s_nxt.busy ? s_nxt.txSh[0] : 1'b1);
        s_nxt.txPin = s_nxt.mode[MODE_ALT_BIT] ? 1'b1 : txOut;
        s_nxt.altTxPin = s_nxt.mode[MODE_ALT_BIT] ? txOut : 1'b1;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign avs_readdata = s_r.rdata;
    assign avs_waitrequest = s_r.waitr;
    assign tx_pin = s_r.txPin;
    assign alt_tx_pin = s_r.altTxPin;
    assign tx_irq_flag = s_r.txIrq;
    assign rx_irq_flag = s_r.rxIrq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_alt_tx_idle: assert property (s_nxt.mode[MODE_ALT_BIT] |=> tx_pin)
        else $error("primary tx pin active while alternate selected");
    a_break_forces_low: assert property (s_nxt.brk |=> !(s_r.mode[MODE_ALT_BIT] ? alt_tx_pin : tx_pin))
        else $error("break did not force tx low");
    a_tx_full_drop: assert property (commit && avs_write && avs_address == REG_TX && !txLoad
        && s_r.txCnt == TCW'(TXQ_DEPTH) |=> $stable(s_r.txCnt) && $stable(s_r.txq))
        else $error("write to full tx buffer changed it");
    a_tx_irq_every: assert property (txLoad && !s_r.txIsel |=> tx_irq_flag)
        else $error("tx flag missing on word move");
    a_tx_start_now: assert property (txLoad |=> s_r.busy ##1 !(s_r.mode[MODE_ALT_BIT] ? alt_tx_pin
        : tx_pin) || s_r.brk)
        else $error("start bit not driven after load");
    a_rx_push_count: assert property (rxPush && !rxPop |=> s_r.rxCnt == $past(s_r.rxCnt) + RCW'(1))
        else $error("rx push did not grow buffer");
    a_rx_overrun: assert property (rxFinish && !rxPush && s_nxt.mode[MODE_EN_BIT]
        |=> s_r.rx_overrun_err && s_r.rxSt != RX_RUN)
        else $error("overrun not flagged on full buffer");
    a_rx_start_edge: assert property ($rose(s_r.rxSt == RX_RUN) |-> $past(rxFall))
        else $error("reception began without falling edge");
    a_disable_clear: assert property (!s_nxt.mode[MODE_EN_BIT] |=> s_r.txCnt == '0
        && s_r.rxCnt == '0 && !s_r.rx_overrun_err && !s_r.busy)
        else $error("disable left state behind");
    a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer timing wrong");

    c_tx_load: cover property (txLoad ##[1:1000] !s_r.busy);
    c_rx_push: cover property (rxPush);
    c_rx_overrun: cover property ($rose(s_r.rx_overrun_err));
    c_rx_break: cover property (s_r.rxSt == RX_BRKWAIT ##1 s_r.rxSt == RX_IDLE);
endmodule : uat_serial

// *** uat_remote.sv ***
`timescale 1ns/100ps
module uat_remote #(
    parameter int BIT_CLKS = 32
) (
    input wire logic clk,
    input wire logic lineIn,
    output logic lineOut
);
    // Line rests high between frames, as a pulled-up idle line would
    initial lineOut = 1'b1;

    task automatic hold(input logic b, input int n);
        lineOut <= b;
        repeat (n * BIT_CLKS) @(posedge clk);
    endtask : hold

    // Par: 0 none, 1 even, 2 odd; flipPar and lowStop corrupt the frame on command
    task automatic send(input logic [8:0] d, input int nData, input int par, input int nStop,
                        input logic flipPar, input logic lowStop);
        hold(1'b0, 1);
        for (int i = 0; i < nData; i++) hold(d[i], 1);
        if (par != 0) hold((^d[7:0]) ^ (par == 2) ^ flipPar, 1);
        if (nStop == 2) hold(1'b1, 1);
        hold(!lowStop, 1);
        hold(1'b1, 1);
    endtask : send

    // Samples each bit at its centre, starting from the falling edge of the start bit
    task automatic recv(output logic [8:0] d, input int nData);
        d = '0;
        while (lineIn !== 1'b0) @(posedge clk);
        repeat (BIT_CLKS / 2) @(posedge clk);
        for (int i = 0; i < nData; i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            d[i] = lineIn;
        end
        repeat (BIT_CLKS) @(posedge clk);
    endtask : recv
endmodule : uat_remote

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
    import uat_pkg::*;
    localparam int BIT = 32;
    logic clk = 1'b0;
    logic arstN = 1'b0;
    logic [2:0] avs_address = 3'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic txPin;
    logic altTxPin;
    logic txIrq;
    logic rxIrq;
    logic lineOut;
    logic altSel = 1'b0;
    logic [15:0] q;
    logic [8:0] got [5];
    int n_mismatch = 0;
    int n_compared = 0;

    uat_serial uat_serial_i (.clk(clk), .arst_n(arstN), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'h3),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_pin(altSel ? 1'b1 : lineOut),
        .alt_rx_pin(altSel ? lineOut : 1'b1), .tx_pin(txPin), .alt_tx_pin(altTxPin),
        .tx_irq_flag(txIrq), .rx_irq_flag(rxIrq));
    uat_remote #(.BIT_CLKS(BIT)) uat_remote_i (.clk(clk), .lineIn(altSel ? altTxPin : txPin),
        .lineOut(lineOut));

    initial forever #4 clk = ~clk;

    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [15:0] exp, input logic [15:0] seen, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic bus(input logic [2:0] a, input logic w, input logic [15:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {16'h0000, d};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[15:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic rdchk(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e,
                         input string what);
        bus(a, 1'b0, 16'h0000);
        chk(e, q & m, what);
    endtask : rdchk

    task automatic t_reset;
        rdchk(REG_MODE, 16'hffff, MODE_RST, "mode");
        rdchk(REG_STA, 16'hffff, 16'h0110, "status");
        rdchk(3'h6, 16'hffff, 16'h0000, "unmapped");
        chk(16'h1, {15'h0, txPin}, "tx idle");
        bus(REG_BRG, 1'b1, 16'h0001);
        bus(REG_MODE, 1'b1, 16'h8000);
    endtask : t_reset

    task automatic t_txqueue;
        bus(REG_STA, 1'b1, 16'h8400);
        fork
            for (int i = 0; i < 5; i++) begin
                uat_remote_i.recv(got[i], 8);
                if (i == 1) chk(16'h0, {15'h0, txIrq}, "tx flag mid");
                if (i == 1) chk(16'h1, {15'h0, altTxPin}, "alt idle");
            end
            begin
                for (int i = 0; i < 6; i++) bus(REG_TX, 1'b1, 16'h0030 + 16'(i));
                rdchk(REG_STA, 16'h0200, 16'h0200, "tx full");
                bus(REG_IRQ, 1'b1, 16'h0001);
            end
        join
        for (int i = 0; i < 5; i++) chk(16'h0030 + 16'(i), {7'h0, got[i]}, "tx word");
        chk(16'h1, {15'h0, txIrq}, "tx flag drained");
        chk(16'h1, {15'h0, txPin}, "tx rest");
    endtask : t_txqueue

    task automatic t_late;
        bus(REG_STA, 1'b1, 16'h0000);
        bus(REG_MODE, 1'b1, 16'h8406);
        altSel <= 1'b1;
        bus(REG_TX, 1'b1, 16'h01a5);
        repeat (4 * BIT) @(posedge clk);
        chk(16'h1, {15'h0, altTxPin}, "held word");
        fork
            uat_remote_i.recv(got[0], 9);
            begin
                bus(REG_STA, 1'b1, 16'h0400);
                repeat (5) @(posedge clk);
                chk(16'h0, {15'h0, altTxPin}, "start at once");
                chk(16'h1, {15'h0, txPin}, "primary idle");
            end
        join
        chk(16'h01a5, {7'h0, got[0]}, "alt word");
        altSel <= 1'b0;
    endtask : t_late

    task automatic rx_one(input logic [15:0] mode, input logic [8:0] d, input int nd,
                          input int par, input int ns, input logic fp, input logic ls,
                          input logic [15:0] flags);
        bus(REG_MODE, 1'b1, mode);
        bus(REG_IRQ, 1'b1, 16'h0002);
        uat_remote_i.send(d, nd, par, ns, fp, ls);
        chk(16'h1, {15'h0, rxIrq}, "rx flag");
        rdchk(REG_STA, 16'h000d, flags, "rx flags");
        rdchk(REG_RX, 16'h01ff, {7'h0, d}, "rx word");
    endtask : rx_one

    task automatic t_rx;
        rx_one(16'h8000, 9'h0c3, 8, 0, 1, 1'b0, 1'b0, 16'h0001);
        rx_one(16'h8002, 9'h0c3, 8, 1, 1, 1'b0, 1'b0, 16'h0001);
        rx_one(16'h8002, 9'h0c1, 8, 1, 1, 1'b1, 1'b0, 16'h0009);
        bus(REG_STA, 1'b1, 16'h0440);
        rx_one(16'h8004, 9'h0c1, 8, 2, 1, 1'b0, 1'b0, 16'h0001);
        rx_one(16'h8004, 9'h0c3, 8, 2, 1, 1'b1, 1'b0, 16'h0009);
        rx_one(16'h8007, 9'h1a5, 9, 0, 2, 1'b0, 1'b0, 16'h0001);
        rx_one(16'h8001, 9'h05a, 8, 0, 2, 1'b0, 1'b1, 16'h0005);
    endtask : t_rx

    task automatic t_rxfull;
        bus(REG_MODE, 1'b1, 16'h8000);
        bus(REG_STA, 1'b1, 16'h0480);
        bus(REG_IRQ, 1'b1, 16'h0003);
        for (int i = 0; i < 6; i++) begin
            uat_remote_i.send(9'h040 + 9'(i), 8, 0, 1, 1'b0, 1'b0);
            if (i == 1) chk(16'h0, {15'h0, rxIrq}, "rx flag two");
            if (i == 2) chk(16'h1, {15'h0, rxIrq}, "rx flag three");
            if (i == 2) bus(REG_STA, 1'b1, 16'h04c0);
            if (i == 2) bus(REG_IRQ, 1'b1, 16'h0002);
            if (i == 3) chk(16'h1, {15'h0, rxIrq}, "rx flag four");
        end
        rdchk(REG_STA, 16'h0003, 16'h0003, "overrun");
        for (int i = 0; i < 4; i++) rdchk(REG_RX, 16'h01ff, 16'h0040 + 16'(i), "queue");
        rdchk(REG_STA, 16'h0001, 16'h0000, "rx empty");
        rdchk(REG_RX, 16'h01ff, 16'h0043, "empty read");
        bus(REG_STA, 1'b1, 16'h04c0);
        rdchk(REG_STA, 16'h0003, 16'h0000, "overrun cleared");
    endtask : t_rxfull

    task automatic t_break;
        bus(REG_IRQ, 1'b1, 16'h0003);
        bus(REG_STA, 1'b1, 16'h0c00);
        for (int i = 0; i < 13; i++) begin
            repeat (BIT) @(posedge clk);
            chk(16'h0, {15'h0, txPin}, "break level");
        end
        bus(REG_TX, 1'b1, 16'h0055);
        repeat (BIT) @(posedge clk);
        chk(16'h0, {15'h0, txIrq}, "break load");
        chk(16'h0, {15'h0, txPin}, "break over data");
        bus(REG_STA, 1'b1, 16'h0000);
        repeat (2 * BIT) @(posedge clk);
        chk(16'h1, {15'h0, txPin}, "after break");
        chk(16'h0, {15'h0, txIrq}, "break flag");
        fork
            uat_remote_i.hold(1'b0, 14);
            begin
                repeat (3 * BIT) @(posedge clk);
                rdchk(REG_STA, 16'h0010, 16'h0000, "rx busy");
            end
        join
        uat_remote_i.hold(1'b1, 2);
        rdchk(REG_STA, 16'h0015, 16'h0015, "break flags");
        chk(16'h1, {15'h0, rxIrq}, "break rx flag");
        rdchk(REG_RX, 16'h01ff, 16'h0000, "break word");
    endtask : t_break

    task automatic t_reset2;
        uat_remote_i.send(9'h033, 8, 0, 1, 1'b0, 1'b0);
        arstN <= 1'b0;
        repeat (3) @(posedge clk);
        arstN <= 1'b1;
        rdchk(REG_STA, 16'hffff, 16'h0110, "status after reset");
    endtask : t_reset2

    initial begin
        repeat (10) @(posedge clk);
        arstN <= 1'b1;
        t_reset();
        t_txqueue();
        t_late();
        t_rx();
        t_rxfull();
        t_break();
        t_reset2();
        report_and_stop();
    end

    initial begin
        repeat (80000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule : tb_top
